// >>> oss_pkg.sv
// Package: register map, field layout and timing for the oscillator switch
package oss_pkg;

    // Register indices on the plain register port
    localparam logic [7:0] OSS_ADDR_STATUS  = 8'hc5;
    localparam logic [7:0] OSS_ADDR_PWRCTL  = 8'hc4;
    localparam logic [7:0] OSS_ADDR_IRQ_ST  = 8'hc9;
    localparam logic [7:0] OSS_ADDR_IRQ_EN  = 8'hca;
    localparam logic [7:0] OSS_ADDR_IRQ_CLR = 8'hcb;

    // Field positions in power_clock_control
    localparam int OSS_PC_XSEL   = 7;
    localparam int OSS_PC_RCACT  = 6;
    localparam int OSS_PC_RCRES  = 5;
    localparam int OSS_PC_SUBOFF = 4;
    localparam int OSS_PC_MAINOFF = 3;
    localparam int OSS_PC_ONE    = 0;

    // Field positions in clock_status
    localparam int OSS_ST_SUBRDY  = 7;
    localparam int OSS_ST_MAINRDY = 4;

    // Interrupt status bits
    localparam int OSS_IRQ_MAINRDY = 0;
    localparam int OSS_IRQ_SUBRDY  = 1;
    localparam int OSS_IRQ_SWITCH  = 2;
    localparam int OSS_IRQ_W       = 3;

    // Warm-up counts in oscillator clocks
    localparam int OSS_MAIN_WARM_SHORT = 4096;
    localparam int OSS_MAIN_WARM_LONG  = 65536;
    localparam int OSS_SUB_WARM_SHORT  = 1024;
    localparam int OSS_SUB_WARM_LONG   = 65536;
    localparam int OSS_CNT_W           = 17;

    // Cycles spent in the gap state; the old clock is held low one cycle more than this before the new one is released
    localparam int OSS_SWITCH_GAP = 2;

    // Reset kinds seen by the block
    typedef enum logic [1:0]
    {
        OSS_RST_NONE = 2'h0,
        OSS_RST_FULL = 2'h1,
        OSS_RST_WDT  = 2'h2
    } oss_rst_kind_t;

    // Register port request
    typedef struct packed
    {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } oss_req_t;

    // Clock source control handed to the analogue side
    typedef struct packed
    {
        logic main_osc_en;
        logic sub_osc_en;
        logic sel_crystal;
        logic gate_crystal;
        logic gate_rc;
    } oss_clk_ctl_t;

endpackage

// >>> oss_switch.sv
// Clock source selection, oscillator warm-up and ready flags
//
// Notes on behaviour
// - crystal_select one runs from crystal, zero from on-chip RC.
// - setting crystal_select ignored unless main ready and main enabled.
// - full reset sets crystal_select; watchdog reset keeps it.
// - rc_active_status reads zero on crystal, one on RC.
// - full reset clears rc_active_status and rc_on_resume_select.
// - resume with rc_on_resume_select runs RC, else waits crystal warm-up.
// - sub_osc_disable stops the 32 kHz sub-oscillator.
// - main_osc_disable stops crystal; write one only while on RC.
// - clearing main_osc_disable restarts crystal, ready after warm-up.
// - sub ready set after warm-up, cleared when sub disabled.
// - option picks sub warm-up of 1024 or 65536 clocks.
// - main ready cleared on power-down exit restart and on disable.
// - power-on reset sets main ready.
// - option picks main warm-up of 4096 or 65536 clocks.
//
// The plain strobed port was decided locally.
module oss_switch
    import oss_pkg::*;
(
    input  wire logic                  i_mclk,
    input  wire logic                  i_rst_n,
    input  wire oss_pkg::oss_rst_kind_t i_rst_kind,
    input  wire logic                  i_main_osc_clk,
    input  wire logic                  i_sub_osc_clk,
    input  wire logic                  i_opt_main_long,
    input  wire logic                  i_opt_sub_long,
    input  wire logic                  i_pd_active,
    input  wire logic                  i_pd_wake,
    input  wire oss_pkg::oss_req_t     i_req,
    output logic [7:0]                 o_rdata,
    output oss_pkg::oss_clk_ctl_t      o_clk_ctl,
    output logic                       o_cpu_hold,
    output logic                       o_irq
);

    ////////////////////////////////////////////////////////////////////
    // Synchronisers and edge detect for the oscillator clocks
    logic [2:0] main_sync_r;
    logic [2:0] main_sync_nxt;
    logic [2:0] sub_sync_r;
    logic [2:0] sub_sync_nxt;
    logic       main_tick;
    logic       sub_tick;

    // Stage 0 feeds stage 1 only; edges found on stages 1 and 2
    always_comb
    begin
        main_sync_nxt = {main_sync_r[1:0], i_main_osc_clk};
        sub_sync_nxt  = {sub_sync_r[1:0], i_sub_osc_clk};
        main_tick     = main_sync_r[1] & ~main_sync_r[2];
        sub_tick      = sub_sync_r[1] & ~sub_sync_r[2];
    end

    always_ff @(posedge i_mclk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            main_sync_r <= 3'h0;
            sub_sync_r  <= 3'h0;
        end
        else
        begin
            main_sync_r <= main_sync_nxt;
            sub_sync_r  <= sub_sync_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Control register, warm-up counters and ready flags
    typedef enum logic [2:0]
    {
        SW_IDLE  = 3'b001,
        SW_GAP   = 3'b010,
        SW_APPLY = 3'b100
    } oss_sw_state_t;

    logic                 xsel_r, xsel_nxt;
    logic                 rcact_r, rcact_nxt;
    logic                 rcres_r, rcres_nxt;
    logic                 suboff_r, suboff_nxt;
    logic                 mainoff_r, mainoff_nxt;
    logic                 mainrdy_r, mainrdy_nxt;
    logic                 subrdy_r, subrdy_nxt;
    logic                 pd_r, pd_nxt;
    logic                 hold_r, hold_nxt;
    logic [OSS_CNT_W-1:0] main_cnt_r, main_cnt_nxt;
    logic [OSS_CNT_W-1:0] sub_cnt_r, sub_cnt_nxt;
    oss_sw_state_t        sw_r, sw_nxt;
    logic [1:0]           gap_r, gap_nxt;
    logic                 target_rc_r, target_rc_nxt;
    logic                 gate_x_r, gate_x_nxt;
    logic                 gate_rc_r, gate_rc_nxt;
    logic                 main_done;
    logic                 sub_done;
    logic                 pc_wr;
    logic                 want_rc;

    // Warm-up length chosen by the factory option bit
    function automatic logic [OSS_CNT_W-1:0] warm_len(input logic lng,
                                                       input int   s,
                                                       input int   l);
        warm_len = lng ? OSS_CNT_W'(l - 1) : OSS_CNT_W'(s - 1);
    endfunction

    always_comb
    begin
        xsel_nxt      = xsel_r;
        rcres_nxt     = rcres_r;
        suboff_nxt    = suboff_r;
        mainoff_nxt   = mainoff_r;
        mainrdy_nxt   = mainrdy_r;
        subrdy_nxt    = subrdy_r;
        main_cnt_nxt  = main_cnt_r;
        sub_cnt_nxt   = sub_cnt_r;
        hold_nxt      = hold_r;
        pd_nxt        = i_pd_active;
        rcact_nxt     = rcact_r;
        sw_nxt        = sw_r;
        gap_nxt       = gap_r;
        target_rc_nxt = target_rc_r;
        gate_x_nxt    = gate_x_r;
        gate_rc_nxt   = gate_rc_r;
        pc_wr         = i_req.wr && (i_req.addr == OSS_ADDR_PWRCTL);
        main_done     = main_cnt_r ==
                        warm_len(i_opt_main_long, OSS_MAIN_WARM_SHORT,
                                 OSS_MAIN_WARM_LONG);
        sub_done      = sub_cnt_r ==
                        warm_len(i_opt_sub_long, OSS_SUB_WARM_SHORT,
                                 OSS_SUB_WARM_LONG);

        // Software writes; bit zero is expected one and not stored
        if (pc_wr)
        begin
            rcres_nxt  = i_req.wdata[OSS_PC_RCRES];
            suboff_nxt = i_req.wdata[OSS_PC_SUBOFF];
            if (!i_req.wdata[OSS_PC_XSEL])
                xsel_nxt = 1'b0;
            else if (mainrdy_r && !mainoff_r)
                xsel_nxt = 1'b1;
            if (!i_req.wdata[OSS_PC_MAINOFF])
                mainoff_nxt = 1'b0;
            else if (rcact_r)
                mainoff_nxt = 1'b1;
        end

        // Main warm-up: restart on enable or power-down exit
        if (mainoff_nxt)
        begin
            mainrdy_nxt  = 1'b0;
            main_cnt_nxt = '0;
        end
        else if (pd_r && !i_pd_active)
        begin
            mainrdy_nxt  = 1'b0;
            main_cnt_nxt = '0;
            hold_nxt     = !rcres_r;
        end
        else if (mainoff_r && !mainoff_nxt)
            main_cnt_nxt = '0;
        else if (!mainrdy_r && main_tick)
        begin
            if (main_done)
                mainrdy_nxt = 1'b1;
            else
                main_cnt_nxt = main_cnt_r + OSS_CNT_W'(1);
        end
        // Ready must still hold, so the resume cycle's set is not lost
        if (mainrdy_r && mainrdy_nxt)
            hold_nxt = 1'b0;

        // Sub warm-up
        if (suboff_nxt)
        begin
            subrdy_nxt  = 1'b0;
            sub_cnt_nxt = '0;
        end
        else if (!subrdy_r && sub_tick)
        begin
            if (sub_done)
                subrdy_nxt = 1'b1;
            else
                sub_cnt_nxt = sub_cnt_r + OSS_CNT_W'(1);
        end

        // Resume with RC choice runs from RC until the crystal is ready
        want_rc = !xsel_r || (!mainrdy_r && rcres_r);

        // Break-before-make switchover
        unique case (sw_r)
            SW_IDLE:
            begin
                if (want_rc != rcact_r)
                begin
                    target_rc_nxt = want_rc;
                    gate_x_nxt    = 1'b0;
                    gate_rc_nxt   = 1'b0;
                    gap_nxt       = 2'(OSS_SWITCH_GAP - 1);
                    sw_nxt        = SW_GAP;
                end
            end
            SW_GAP:
            begin
                if (gap_r == 2'h0)
                    sw_nxt = SW_APPLY;
                else
                    gap_nxt = gap_r - 2'h1;
            end
            SW_APPLY:
            begin
                gate_x_nxt  = !target_rc_r;
                gate_rc_nxt = target_rc_r;
                rcact_nxt   = target_rc_r;
                sw_nxt      = SW_IDLE;
            end
            default: sw_nxt = SW_IDLE;
        endcase
    end

    // Full reset loads defaults; watchdog reset keeps the select bits
    always_ff @(posedge i_mclk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            xsel_r      <= 1'b1;
            rcact_r     <= 1'b0;
            rcres_r     <= 1'b0;
            suboff_r    <= 1'b0;
            mainoff_r   <= 1'b0;
            mainrdy_r   <= 1'b1;
            subrdy_r    <= 1'b0;
            main_cnt_r  <= '0;
            sub_cnt_r   <= '0;
            pd_r        <= 1'b0;
            hold_r      <= 1'b0;
            sw_r        <= SW_IDLE;
            gap_r       <= 2'h0;
            target_rc_r <= 1'b0;
            gate_x_r    <= 1'b1;
            gate_rc_r   <= 1'b0;
        end
        else if (i_rst_kind == OSS_RST_FULL)
        begin
            xsel_r      <= 1'b1;
            rcact_r     <= 1'b0;
            rcres_r     <= 1'b0;
            suboff_r    <= 1'b0;
            mainoff_r   <= 1'b0;
            // Both gates shut, crystal opened after the gap: no runt
            sw_r        <= SW_GAP;
            gap_r       <= 2'(OSS_SWITCH_GAP - 1);
            target_rc_r <= 1'b0;
            gate_x_r    <= 1'b0;
            gate_rc_r   <= 1'b0;
            hold_r      <= 1'b0;
        end
        else if (i_rst_kind == OSS_RST_WDT)
        begin
            // Select bits kept; only the oscillator disables drop
            suboff_r    <= 1'b0;
            mainoff_r   <= 1'b0;
        end
        else
        begin
            xsel_r      <= xsel_nxt;
            rcact_r     <= rcact_nxt;
            rcres_r     <= rcres_nxt;
            suboff_r    <= suboff_nxt;
            mainoff_r   <= mainoff_nxt;
            mainrdy_r   <= mainrdy_nxt;
            subrdy_r    <= subrdy_nxt;
            main_cnt_r  <= main_cnt_nxt;
            sub_cnt_r   <= sub_cnt_nxt;
            pd_r        <= pd_nxt;
            hold_r      <= hold_nxt;
            sw_r        <= sw_nxt;
            gap_r       <= gap_nxt;
            target_rc_r <= target_rc_nxt;
            gate_x_r    <= gate_x_nxt;
            gate_rc_r   <= gate_rc_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Interrupt flags, read port and registered outputs
    logic [OSS_IRQ_W-1:0] ist_r, ist_nxt;
    logic [OSS_IRQ_W-1:0] ien_r, ien_nxt;
    logic [OSS_IRQ_W-1:0] ev;
    logic [7:0]           rdata_nxt;
    oss_clk_ctl_t         ctl_nxt;
    oss_clk_ctl_t         ctl_r;
    logic [7:0]           rdata_r;
    logic                 irq_r;
    logic                 irq_nxt;

    // Set wins over a clear in the same cycle
    always_comb
    begin
        ev                  = '0;
        ev[OSS_IRQ_MAINRDY] = mainrdy_nxt & ~mainrdy_r;
        ev[OSS_IRQ_SUBRDY]  = subrdy_nxt & ~subrdy_r;
        ev[OSS_IRQ_SWITCH]  = rcact_nxt ^ rcact_r;
        ist_nxt             = ist_r;
        ien_nxt             = ien_r;
        if (i_req.wr && i_req.addr == OSS_ADDR_IRQ_CLR)
            ist_nxt = ist_nxt & ~i_req.wdata[OSS_IRQ_W-1:0];
        if (i_req.wr && i_req.addr == OSS_ADDR_IRQ_EN)
            ien_nxt = i_req.wdata[OSS_IRQ_W-1:0];
        ist_nxt = ist_nxt | ev;
        irq_nxt = |(ist_nxt & ien_nxt);

        rdata_nxt = 8'h00;
        if (i_req.rd)
        begin
            unique case (i_req.addr)
                OSS_ADDR_STATUS:
                begin
                    rdata_nxt[OSS_ST_SUBRDY]  = subrdy_r;
                    rdata_nxt[OSS_ST_MAINRDY] = mainrdy_r;
                end
                OSS_ADDR_PWRCTL:
                begin
                    rdata_nxt[OSS_PC_XSEL]    = xsel_r;
                    rdata_nxt[OSS_PC_RCACT]   = rcact_r;
                    rdata_nxt[OSS_PC_RCRES]   = rcres_r;
                    rdata_nxt[OSS_PC_SUBOFF]  = suboff_r;
                    rdata_nxt[OSS_PC_MAINOFF] = mainoff_r;
                    rdata_nxt[OSS_PC_ONE]     = 1'b1;
                end
                OSS_ADDR_IRQ_ST: rdata_nxt[OSS_IRQ_W-1:0] = ist_r;
                OSS_ADDR_IRQ_EN: rdata_nxt[OSS_IRQ_W-1:0] = ien_r;
                default:         rdata_nxt = 8'h00;
            endcase
        end

        ctl_nxt.main_osc_en  = !mainoff_r;
        ctl_nxt.sub_osc_en   = !suboff_r;
        ctl_nxt.sel_crystal  = !rcact_r;
        ctl_nxt.gate_crystal = gate_x_r;
        ctl_nxt.gate_rc      = gate_rc_r;
    end

    // Outputs all registered so nothing glitches at the pins
    always_ff @(posedge i_mclk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            ist_r   <= '0;
            ien_r   <= '0;
            irq_r   <= 1'b0;
            rdata_r <= 8'h00;
            ctl_r   <= '{main_osc_en: 1'b1, sub_osc_en: 1'b1,
                         sel_crystal: 1'b1, gate_crystal: 1'b1,
                         gate_rc: 1'b0};
        end
        else
        begin
            ist_r   <= ist_nxt;
            ien_r   <= ien_nxt;
            irq_r   <= irq_nxt;
            rdata_r <= rdata_nxt;
            ctl_r   <= ctl_nxt;
        end
    end

    assign o_rdata    = rdata_r;
    assign o_clk_ctl  = ctl_r;
    assign o_cpu_hold = hold_r;
    assign o_irq      = irq_r;

endmodule

// >>> oss_switch_monitor.sv
// Checker: port-level properties of the oscillator source switch
module oss_switch_monitor
    import oss_pkg::*;
(
    input  wire logic                   i_mclk,
    input  wire logic                   i_rst_n,
    input  wire oss_pkg::oss_rst_kind_t i_rst_kind,
    input  wire oss_pkg::oss_req_t      i_req,
    input  wire logic [7:0]             o_rdata,
    input  wire oss_pkg::oss_clk_ctl_t  o_clk_ctl,
    input  wire logic                   o_cpu_hold
);
    timeunit 1ns;
    timeprecision 1ps;

    logic wr_ctl;

    ////////////////////////////////////////////////////////////////////////
    // Control writes the block really takes, not those under a reset load
    assign wr_ctl = i_req.wr && i_req.addr == OSS_ADDR_PWRCTL
                    && i_rst_kind == OSS_RST_NONE;

    default clocking cb @(posedge i_mclk);
    endclocking
    default disable iff (!i_rst_n);

    ////////////////////////////////////////////////////////////////////////
    // Read data only in the cycle after a read strobe
    rdata_idle_a: assert property (!$past(i_req.rd) |-> o_rdata == 8'h00)
        else $error("read data outside read slot");
    one_bit_a: assert property (
        i_req.rd && i_req.addr == OSS_ADDR_PWRCTL |=> o_rdata[OSS_PC_ONE])
        else $error("control bit zero not read as one");
    // Never both gates open: that is where a runt pulse would come from
    gate_excl_a: assert property (
        !(o_clk_ctl.gate_crystal && o_clk_ctl.gate_rc))
        else $error("both clock gates open");
    src_match_a: assert property (
        o_clk_ctl.gate_crystal |-> o_clk_ctl.sel_crystal)
        else $error("crystal gate open without crystal select");
    rc_gap_a: assert property (
        $fell(o_clk_ctl.gate_crystal) |-> !o_clk_ctl.gate_rc [*2])
        else $error("rc gate opened without gap");
    xtal_gap_a: assert property (
        $fell(o_clk_ctl.gate_rc) |-> !o_clk_ctl.gate_crystal [*2])
        else $error("crystal gate opened without gap");
    switch_time_a: assert property (
        wr_ctl && !i_req.wdata[OSS_PC_XSEL] && o_clk_ctl.gate_crystal
        |-> ##[1:8] o_clk_ctl.gate_rc)
        else $error("switch to rc not completed");
    main_keep_a: assert property (
        wr_ctl && i_req.wdata[OSS_PC_MAINOFF] && o_clk_ctl.gate_crystal
        |=> ##1 o_clk_ctl.main_osc_en)
        else $error("crystal stopped while running from it");
    main_stop_a: assert property (
        wr_ctl && i_req.wdata[OSS_PC_MAINOFF] && o_clk_ctl.gate_rc
        |-> ##[1:2] !o_clk_ctl.main_osc_en)
        else $error("crystal not stopped");
    sub_stop_a: assert property (
        wr_ctl && i_req.wdata[OSS_PC_SUBOFF]
        |-> ##[1:2] !o_clk_ctl.sub_osc_en)
        else $error("sub oscillator not stopped");
    hold_no_rc_a: assert property (
        o_cpu_hold |-> !o_clk_ctl.gate_rc)
        else $error("rc clock running during hold");
endmodule

// >>> oss_osc_model.sv
// Partner model: crystal and 32 kHz oscillators, stopped while disabled
module oss_osc_model
(
    input  wire logic i_main_en,
    input  wire logic i_sub_en,
    output logic      o_main_clk,
    output logic      o_sub_clk
);
    timeunit 1ns;
    timeprecision 1ps;

    // Scaled rates keep warm-ups short; both stay below half of i_mclk
    initial o_main_clk = 1'b0;
    initial o_sub_clk = 1'b0;

    // A disabled oscillator stands still low, so no edge gets counted
    always #20 o_main_clk = i_main_en ? ~o_main_clk : 1'b0;
    always #22 o_sub_clk = i_sub_en ? ~o_sub_clk : 1'b0;
endmodule

// >>> testbench.sv
// Testbench: registers, switchover, warm-up, reset kinds and resume
module testbench
    import oss_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic          i_mclk;
    logic          i_rst_n;
    oss_rst_kind_t i_rst_kind;
    logic          i_pd_active;
    oss_req_t      i_req;
    logic [7:0]    o_rdata;
    oss_clk_ctl_t  o_clk_ctl;
    logic          o_cpu_hold;
    logic          o_irq;
    logic          main_clk;
    logic          sub_clk;
    int            miscompares;
    int            checks;

    ////////////////////////////////////////////////////////////////////////
    // Options tied short; the wake input is a spare
    oss_switch i_dut (
        .i_mclk          (i_mclk),
        .i_rst_n         (i_rst_n),
        .i_rst_kind      (i_rst_kind),
        .i_main_osc_clk  (main_clk),
        .i_sub_osc_clk   (sub_clk),
        .i_opt_main_long (1'b0),
        .i_opt_sub_long  (1'b0),
        .i_pd_active     (i_pd_active),
        .i_pd_wake       (1'b0),
        .i_req           (i_req),
        .o_rdata         (o_rdata),
        .o_clk_ctl       (o_clk_ctl),
        .o_cpu_hold      (o_cpu_hold),
        .o_irq           (o_irq)
    );

    oss_osc_model i_osc (
        .i_main_en  (o_clk_ctl.main_osc_en),
        .i_sub_en   (o_clk_ctl.sub_osc_en),
        .o_main_clk (main_clk),
        .o_sub_clk  (sub_clk)
    );

    // Clock
    always #5 i_mclk = ~i_mclk;

    ////////////////////////////////////////////////////////////////////////
    task automatic give_verdict();
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic chk_bit(input string n, input logic e, input logic g);
        checks++;
        if (g !== e)
        begin
            miscompares++;
            $display("[ERR] %s exp %b got %b", n, e, g);
        end
    endtask

    task automatic chk_byte(input string n, input logic [7:0] e,
                            input logic [7:0] g);
        checks++;
        if (g !== e)
        begin
            miscompares++;
            $display("[ERR] %s exp %h got %h", n, e, g);
        end
    endtask

    // Settles one step past the edge so flags are read after they land
    task automatic tick(input int n);
        repeat (n) @(posedge i_mclk);
        #1;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_mclk);
        i_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge i_mclk);
        i_req.wr <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge i_mclk);
        i_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge i_mclk);
        i_req.rd <= 1'b0;
        #1 d = o_rdata;
    endtask

    task automatic rd_chk(input string n, input logic [7:0] a,
                          input logic [7:0] e);
        logic [7:0] d;
        rd(a, d);
        chk_byte(n, e, d);
    endtask

    task automatic rd_bit(input string n, input logic [7:0] a, input int p,
                          input logic e);
        logic [7:0] d;
        rd(a, d);
        chk_bit(n, e, d[p]);
    endtask

    // Polls a register bit; a bound that runs out ends the run
    task automatic wait_bit(input logic [7:0] a, input int p, input logic v,
                            input int n);
        logic [7:0] d;
        repeat (n)
        begin
            rd(a, d);
            if (d[p] === v)
                return;
        end
        miscompares++;
        $display("[ERR] wait %h bit %0d exp %b got %b", a, p, v, d[p]);
        give_verdict();
    endtask

    task automatic pulse_kind(input oss_rst_kind_t k);
        @(posedge i_mclk);
        i_rst_kind <= k;
        @(posedge i_mclk);
        i_rst_kind <= OSS_RST_NONE;
    endtask

    task automatic pd_pulse();
        @(posedge i_mclk);
        i_pd_active <= 1'b1;
        tick(20);
        @(posedge i_mclk);
        i_pd_active <= 1'b0;
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        rd_chk("ctl", OSS_ADDR_PWRCTL, 8'h81);
        rd_chk("status", OSS_ADDR_STATUS, 8'h10);
        chk_bit("sel", 1'b1, o_clk_ctl.sel_crystal);
        rd_chk("unmapped", 8'hc0, 8'h00);
        wr(OSS_ADDR_PWRCTL, 8'h89);
        rd_chk("ctl off refused", OSS_ADDR_PWRCTL, 8'h81);
        chk_bit("main en", 1'b1, o_clk_ctl.main_osc_en);
        $display("test reset done");
    endtask

    task automatic t_to_rc();
        wr(OSS_ADDR_IRQ_EN, 8'h04);
        wr(OSS_ADDR_PWRCTL, 8'h01);
        wait_bit(OSS_ADDR_PWRCTL, OSS_PC_RCACT, 1'b1, 8);
        chk_bit("sel rc", 1'b0, o_clk_ctl.sel_crystal);
        chk_bit("irq", 1'b1, o_irq);
        wr(OSS_ADDR_IRQ_EN, 8'h00);
        tick(2);
        chk_bit("irq masked", 1'b0, o_irq);
        rd_bit("irq st", OSS_ADDR_IRQ_ST, OSS_IRQ_SWITCH, 1'b1);
        wr(OSS_ADDR_IRQ_CLR, 8'h04);
        wr(OSS_ADDR_IRQ_EN, 8'h04);
        tick(2);
        chk_bit("irq cleared", 1'b0, o_irq);
        $display("test to_rc done");
    endtask

    task automatic t_main_off();
        wr(OSS_ADDR_PWRCTL, 8'h09);
        tick(3);
        chk_bit("main off", 1'b0, o_clk_ctl.main_osc_en);
        rd_bit("rdy off", OSS_ADDR_STATUS, OSS_ST_MAINRDY, 1'b0);
        wr(OSS_ADDR_PWRCTL, 8'h89);
        rd_chk("xsel refused", OSS_ADDR_PWRCTL, 8'h49);
        wr(OSS_ADDR_PWRCTL, 8'h01);
        tick(8000);
        rd_bit("rdy early", OSS_ADDR_STATUS, OSS_ST_MAINRDY, 1'b0);
        wait_bit(OSS_ADDR_STATUS, OSS_ST_MAINRDY, 1'b1, 10000);
        wr(OSS_ADDR_PWRCTL, 8'hc1);
        wait_bit(OSS_ADDR_PWRCTL, OSS_PC_RCACT, 1'b0, 8);
        wr(OSS_ADDR_PWRCTL, 8'h01);
        wait_bit(OSS_ADDR_PWRCTL, OSS_PC_RCACT, 1'b1, 8);
        $display("test main_off done");
    endtask

    task automatic t_wdt();
        wr(OSS_ADDR_PWRCTL, 8'h61);
        pulse_kind(OSS_RST_WDT);
        rd_chk("ctl wdt", OSS_ADDR_PWRCTL, 8'h61);
        pulse_kind(OSS_RST_FULL);
        wait_bit(OSS_ADDR_PWRCTL, OSS_PC_RCACT, 1'b0, 8);
        rd_chk("ctl full", OSS_ADDR_PWRCTL, 8'h81);
        tick(8);
        chk_bit("sel full", 1'b1, o_clk_ctl.sel_crystal);
        $display("test wdt done");
    endtask

    task automatic t_sub();
        wait_bit(OSS_ADDR_STATUS, OSS_ST_SUBRDY, 1'b1, 4000);
        wr(OSS_ADDR_PWRCTL, 8'h91);
        rd_bit("sub off", OSS_ADDR_STATUS, OSS_ST_SUBRDY, 1'b0);
        chk_bit("sub en", 1'b0, o_clk_ctl.sub_osc_en);
        wr(OSS_ADDR_PWRCTL, 8'h81);
        tick(3000);
        rd_bit("sub early", OSS_ADDR_STATUS, OSS_ST_SUBRDY, 1'b0);
        wait_bit(OSS_ADDR_STATUS, OSS_ST_SUBRDY, 1'b1, 4000);
        $display("test sub done");
    endtask

    task automatic t_resume();
        pd_pulse();
        tick(4);
        chk_bit("hold", 1'b1, o_cpu_hold);
        rd_bit("rdy wake", OSS_ADDR_STATUS, OSS_ST_MAINRDY, 1'b0);
        wait_bit(OSS_ADDR_STATUS, OSS_ST_MAINRDY, 1'b1, 10000);
        tick(4);
        chk_bit("hold end", 1'b0, o_cpu_hold);
        wr(OSS_ADDR_PWRCTL, 8'ha1);
        pd_pulse();
        tick(2);
        chk_bit("no hold", 1'b0, o_cpu_hold);
        wait_bit(OSS_ADDR_PWRCTL, OSS_PC_RCACT, 1'b1, 20);
        wait_bit(OSS_ADDR_STATUS, OSS_ST_MAINRDY, 1'b1, 10000);
        $display("test resume done");
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Main sequence: reset held three cycles, then each scenario in turn
    initial
    begin
        i_mclk = 1'b0;
        i_rst_n = 1'b0;
        i_rst_kind = OSS_RST_NONE;
        i_pd_active = 1'b0;
        i_req = '0;
        miscompares = 0;
        checks = 0;
        repeat (3) @(posedge i_mclk);
        i_rst_n <= 1'b1;
        t_reset();
        t_to_rc();
        t_main_off();
        t_wdt();
        t_sub();
        t_resume();
        give_verdict();
    end
endmodule

bind oss_switch oss_switch_monitor i_mon (
    .i_mclk     (i_mclk),
    .i_rst_n    (i_rst_n),
    .i_rst_kind (i_rst_kind),
    .i_req      (i_req),
    .o_rdata    (o_rdata),
    .o_clk_ctl  (o_clk_ctl),
    .o_cpu_hold (o_cpu_hold)
);
